/* File: design/sspu_map.svh */
// Constants of the stack pointer unit: reset values, steps and register indexes
`ifndef SSPU_MAP_SVH
`define SSPU_MAP_SVH

// Reset values
`define SSPU_SP_RESET       16'h0800
`define SSPU_SP_RESET_ALT   16'h1000
`define SSPU_FP_RESET       16'h0000
`define SSPU_LIMIT_RESET    16'h0000
`define SSPU_STATUS_RESET   3'h0
`define SSPU_MASK_RESET     3'h0

// One stack word in bytes, and the even-address mask
`define SSPU_WORD_STEP      17'h00002
`define SSPU_EVEN_MASK      16'hFFFE

// Register indexes on the register port
`define SSPU_REG_ADDR_W     3
`define SSPU_REG_LIMIT      3'h0
`define SSPU_REG_STATUS     3'h1
`define SSPU_REG_MASK       3'h2
`define SSPU_REG_SP         3'h3
`define SSPU_REG_FP         3'h4

// Event bit positions in status and mask
`define SSPU_EV_W           3
`define SSPU_EV_OVER        0
`define SSPU_EV_UNDER       1
`define SSPU_EV_WRAP        2

`endif

/* File: design/sspu_pkg.sv */
// Types shared by the stack pointer unit
`default_nettype none
package sspu_pkg;
	// Stack operations requested by the pipeline
	typedef enum logic [2:0] {
		SSPU_OP_PUSH    = 3'b000,
		SSPU_OP_POP     = 3'b001,
		SSPU_OP_CALL    = 3'b010,
		SSPU_OP_EXC     = 3'b011,
		SSPU_OP_LINK    = 3'b100,
		SSPU_OP_UNLINK  = 3'b101,
		SSPU_OP_LOAD_SP = 3'b110,
		SSPU_OP_LOAD_FP = 3'b111
	} sspu_op_type;

	// Sequencer states
	typedef enum logic [2:0] {
		SSPU_S_IDLE   = 3'b000,
		SSPU_S_SECOND = 3'b001,
		SSPU_S_LINK   = 3'b010,
		SSPU_S_UNLINK = 3'b011,
		SSPU_S_READ   = 3'b100,
		SSPU_S_WAIT   = 3'b101
	} sspu_state_type;

	typedef logic [15:0] sspu_word_type;
endpackage
`default_nettype wire

/* File: design/sspu_guard.sv */
// Address guard: limit, floor and wrap comparison of a stack effective address
`default_nettype none
module sspu_guard (
	input  wire logic                  chk_valid,
	input  wire logic                  check_en,
	input  wire sspu_pkg::sspu_word_type ea,
	input  wire logic                  wrap,
	input  wire sspu_pkg::sspu_word_type limit,
	input  wire sspu_pkg::sspu_word_type floor,
	output logic                       over,
	output logic                       under,
	output logic                       wrap_err
);
	import sspu_pkg::*;

	// Limit checks only after the limit was armed; the floor check always applies
	always_comb begin
		over     = chk_valid && check_en && (ea > limit);
		under    = chk_valid && (ea < floor);
		wrap_err = chk_valid && check_en && wrap;
	end
endmodule // sspu_guard
`default_nettype wire

/* File: design/sspu_regs.sv */
// Register port of the stack pointer unit: limit, event status, mask, interrupt
`include "sspu_map.svh"
`default_nettype none
module sspu_regs (
	input  wire logic                         clk,
	input  wire logic                         nrst,
	input  wire logic [`SSPU_REG_ADDR_W-1:0]  reg_addr,
	input  wire sspu_pkg::sspu_word_type      reg_wdata,
	input  wire logic                         reg_wr,
	input  wire logic                         reg_rd,
	output sspu_pkg::sspu_word_type           reg_rdata,
	output logic                              irq,
	input  wire logic [`SSPU_EV_W-1:0]        events,
	input  wire sspu_pkg::sspu_word_type      sp,
	input  wire sspu_pkg::sspu_word_type      fp,
	output sspu_pkg::sspu_word_type           limit,
	output logic                              check_en
);
	import sspu_pkg::*;

	logic [`SSPU_EV_W-1:0] status;
	logic [`SSPU_EV_W-1:0] mask;
	logic [`SSPU_EV_W-1:0] next_status;
	logic                  limit_wr;

	assign limit_wr = reg_wr && (reg_addr == `SSPU_REG_LIMIT);

	// Read clears, but a new event in the same cycle survives the clear
	always_comb begin
		next_status = status;
		if (reg_rd && (reg_addr == `SSPU_REG_STATUS)) begin
			next_status = '0;
		end
		next_status = next_status | events;
	end

	// Limit register, bit 0 held at zero
	always_ff @(posedge clk) begin
		if (!nrst) begin
			limit <= `SSPU_LIMIT_RESET;
		end else if (limit_wr) begin
			limit <= reg_wdata & `SSPU_EVEN_MASK;
		end
	end

	// Arming is one way: only reset disarms
	always_ff @(posedge clk) begin
		if (!nrst) begin
			check_en <= 1'b0;
		end else if (limit_wr) begin
			check_en <= 1'b1;
		end
	end

	// Status and mask
	always_ff @(posedge clk) begin
		if (!nrst) begin
			status <= `SSPU_STATUS_RESET;
			mask   <= `SSPU_MASK_RESET;
		end else begin
			status <= next_status;
			if (reg_wr && (reg_addr == `SSPU_REG_MASK)) begin
				mask <= reg_wdata[`SSPU_EV_W-1:0];
			end
		end
	end

	// Level interrupt follows the status as it will stand after this edge
	always_ff @(posedge clk) begin
		if (!nrst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_status & mask);
		end
	end

	// Read data one cycle after the strobe; unmapped indexes read zero
	always_ff @(posedge clk) begin
		if (!nrst) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				`SSPU_REG_LIMIT:  reg_rdata <= limit;
				`SSPU_REG_STATUS: reg_rdata <= {13'h0000, status};
				`SSPU_REG_MASK:   reg_rdata <= {13'h0000, mask};
				`SSPU_REG_SP:     reg_rdata <= sp;
				`SSPU_REG_FP:     reg_rdata <= fp;
				default:          reg_rdata <= '0;
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end
endmodule // sspu_regs
`default_nettype wire

/* File: design/sspu_core.sv */
// Stack pointer unit: pointer sequencing, frame handling and stack error detection
//
// What this block does
// - Reset loads the stack pointer with 0x0800, or 0x1000 when the alternate variant is chosen.
// - The stack pointer names the first free word and the stack grows toward higher addresses.
// - A push writes at the pointer then adds one word; a pop subtracts one word then reads.
// - Push and pop use the same post-increment and pre-decrement path with alignment and checks.
// - A call stacks the low 16 program counter bits first, then the upper 7 bits zero-extended.
// - Exception entry stacks the upper 7 counter bits with the status low byte and priority bit 3.
// - Bit 0 of the stack pointer always reads and holds zero.
// - Reset clears the frame pointer, which otherwise loads like any working register.
// - Frame create pushes the old frame pointer, copies the new stack pointer into it, then adds the literal.
// - Frame release copies the frame pointer into the stack pointer and pops the old frame pointer back.
// - A 16-bit stack limit register resets to zero with bit 0 fixed at zero.
// - Limit checking starts at the first word write to the limit and only reset stops it.
// - With checking on, any stack effective address above the limit raises a stack error.
// - With checking on, a push or pop address calculation that wraps past 0xFFFF raises a stack error.
// - A stack address below 0x0800, or 0x1000 on the alternate variant, raises a stack error.
`include "sspu_map.svh"
`default_nettype none
module sspu_core #(
	parameter bit ALT_VARIANT = 1'b0
) (
	input  wire logic                         clk,
	input  wire logic                         nrst,
	input  wire logic                         op_valid,
	input  wire sspu_pkg::sspu_op_type        op_code,
	input  wire sspu_pkg::sspu_word_type      op_data,
	input  wire logic [22:0]                  pc,
	input  wire logic [7:0]                   status_low_byte,
	input  wire logic                         cpu_priority_level,
	input  wire logic [13:0]                  frame_lit,
	output logic                              op_busy,
	output logic                              op_done,
	output sspu_pkg::sspu_word_type           pop_data,
	output sspu_pkg::sspu_word_type           stack_pointer_reg,
	output sspu_pkg::sspu_word_type           frame_pointer_reg,
	output logic                              mem_wr,
	output logic                              mem_rd,
	output sspu_pkg::sspu_word_type           mem_addr,
	output sspu_pkg::sspu_word_type           mem_wdata,
	input  wire sspu_pkg::sspu_word_type      mem_rdata,
	output logic                              stack_error,
	input  wire logic [`SSPU_REG_ADDR_W-1:0]  reg_addr,
	input  wire sspu_pkg::sspu_word_type      reg_wdata,
	input  wire logic                         reg_wr,
	input  wire logic                         reg_rd,
	output sspu_pkg::sspu_word_type           reg_rdata,
	output logic                              irq
);
	import sspu_pkg::*;

	localparam sspu_word_type SP_INIT = ALT_VARIANT ? `SSPU_SP_RESET_ALT : `SSPU_SP_RESET;

	// Sequencer state and operands kept between steps
	sspu_state_type        state;
	sspu_state_type        next_state;
	sspu_word_type         hold_word;
	sspu_word_type         next_hold;
	logic [13:0]           hold_lit;
	logic                  pop_to_fp;
	logic                  next_pop_to_fp;

	// Next values of the registered outputs
	sspu_word_type         next_sp;
	sspu_word_type         next_fp;
	sspu_word_type         next_addr;
	sspu_word_type         next_wdata;
	sspu_word_type         next_pop;
	logic                  next_wr;
	logic                  next_rd;
	logic                  next_done;

	// Shared push and pop path, and the address handed to the guard
	logic                  do_push;
	logic                  do_pop;
	sspu_word_type         push_word;
	logic [16:0]           step_sum;
	logic [16:0]           step_diff;
	logic                  chk_valid;
	sspu_word_type         chk_ea;
	logic                  chk_wrap;
	logic                  hit_over;
	logic                  hit_under;
	logic                  hit_wrap;
	logic [`SSPU_EV_W-1:0] events;

	// Limit and arming state owned by the register block
	sspu_word_type         limit;
	logic                  check_en;

	// Sequencer: decide the next pointers and the memory access of this step
	always_comb begin
		next_state     = state;
		next_hold      = hold_word;
		next_pop_to_fp = pop_to_fp;
		next_sp        = stack_pointer_reg;
		next_fp        = frame_pointer_reg;
		next_addr      = mem_addr;
		next_wdata     = mem_wdata;
		next_pop       = pop_data;
		next_wr        = 1'b0;
		next_rd        = 1'b0;
		next_done      = 1'b0;
		do_push        = 1'b0;
		do_pop         = 1'b0;
		push_word      = op_data;
		case (state)
			SSPU_S_IDLE: begin
				if (op_valid) begin
					case (op_code)
						SSPU_OP_PUSH: begin
							do_push   = 1'b1;
							next_done = 1'b1;
						end
						SSPU_OP_POP: begin
							do_pop         = 1'b1;
							next_pop_to_fp = 1'b0;
							next_state     = SSPU_S_READ;
						end
						SSPU_OP_CALL: begin
							do_push    = 1'b1;
							push_word  = pc[15:0];
							next_hold  = {9'h000, pc[22:16]};
							next_state = SSPU_S_SECOND;
						end
						SSPU_OP_EXC: begin
							do_push    = 1'b1;
							push_word  = pc[15:0];
							// Status byte and priority bit ride above the upper counter bits
							next_hold  = {status_low_byte, cpu_priority_level, pc[22:16]};
							next_state = SSPU_S_SECOND;
						end
						SSPU_OP_LINK: begin
							do_push    = 1'b1;
							push_word  = frame_pointer_reg;
							next_state = SSPU_S_LINK;
						end
						SSPU_OP_UNLINK: begin
							// Relies on software having paired this with a frame create
							next_sp    = frame_pointer_reg;
							next_state = SSPU_S_UNLINK;
						end
						SSPU_OP_LOAD_SP: begin
							next_sp   = op_data;
							next_done = 1'b1;
						end
						SSPU_OP_LOAD_FP: begin
							next_fp   = op_data;
							next_done = 1'b1;
						end
						default: begin
							next_state = SSPU_S_IDLE;
						end
					endcase
				end
			end
			SSPU_S_SECOND: begin
				do_push    = 1'b1;
				push_word  = hold_word;
				next_done  = 1'b1;
				next_state = SSPU_S_IDLE;
			end
			SSPU_S_LINK: begin
				// Frame pointer takes the pointer after the push, then space is reserved
				next_fp    = stack_pointer_reg;
				next_sp    = stack_pointer_reg + {2'b00, hold_lit};
				next_done  = 1'b1;
				next_state = SSPU_S_IDLE;
			end
			SSPU_S_UNLINK: begin
				do_pop         = 1'b1;
				next_pop_to_fp = 1'b1;
				next_state     = SSPU_S_READ;
			end
			SSPU_S_READ: begin
				next_state = SSPU_S_WAIT;
			end
			SSPU_S_WAIT: begin
				// Read data arrive one cycle after the read strobe
				if (pop_to_fp) begin
					next_fp = mem_rdata;
				end else begin
					next_pop = mem_rdata;
				end
				next_done  = 1'b1;
				next_state = SSPU_S_IDLE;
			end
			default: begin
				next_state = SSPU_S_IDLE;
			end
		endcase
		// Shared post-increment write and pre-decrement read, as a word move would
		step_sum  = {1'b0, stack_pointer_reg} + `SSPU_WORD_STEP;
		step_diff = {1'b0, stack_pointer_reg} - `SSPU_WORD_STEP;
		chk_valid = do_push || do_pop;
		chk_ea    = stack_pointer_reg;
		chk_wrap  = 1'b0;
		if (do_push) begin
			next_wr    = 1'b1;
			next_addr  = stack_pointer_reg;
			next_wdata = push_word;
			next_sp    = step_sum[15:0];
			chk_wrap   = step_sum[16];
		end
		if (do_pop) begin
			next_rd   = 1'b1;
			next_addr = step_diff[15:0];
			next_sp   = step_diff[15:0];
			chk_ea    = step_diff[15:0];
			chk_wrap  = step_diff[16];
		end
	end

	// Guard compares the address about to be presented on the memory port
	sspu_guard u_guard (
		.chk_valid (chk_valid),
		.check_en  (check_en),
		.ea        (chk_ea),
		.wrap      (chk_wrap),
		.limit     (limit),
		.floor     (SP_INIT),
		.over      (hit_over),
		.under     (hit_under),
		.wrap_err  (hit_wrap)
	);

	// Sequencer state; busy is registered so it never depends on the request inputs
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state   <= SSPU_S_IDLE;
			op_busy <= 1'b0;
		end else begin
			state   <= next_state;
			op_busy <= (next_state != SSPU_S_IDLE);
		end
	end

	// Operands kept for later steps of a multi-cycle operation
	always_ff @(posedge clk) begin
		if (!nrst) begin
			hold_word <= '0;
			hold_lit  <= '0;
			pop_to_fp <= 1'b0;
		end else begin
			hold_word <= next_hold;
			pop_to_fp <= next_pop_to_fp;
			if (state == SSPU_S_IDLE && op_valid) begin
				hold_lit <= {frame_lit[13:1], 1'b0};   // Odd byte counts would misalign
			end
		end
	end

	// Stack pointer: bit 0 is cleared on every load so no stack access is odd
	always_ff @(posedge clk) begin
		if (!nrst) begin
			stack_pointer_reg <= SP_INIT;
		end else begin
			stack_pointer_reg <= next_sp & `SSPU_EVEN_MASK;
		end
	end

	// Frame pointer
	always_ff @(posedge clk) begin
		if (!nrst) begin
			frame_pointer_reg <= `SSPU_FP_RESET;
		end else begin
			frame_pointer_reg <= next_fp;
		end
	end

	// Memory strobes, one cycle per access
	always_ff @(posedge clk) begin
		if (!nrst) begin
			mem_wr <= 1'b0;
			mem_rd <= 1'b0;
		end else begin
			mem_wr <= next_wr;
			mem_rd <= next_rd;
		end
	end

	// Address and write data hold their last value between accesses
	always_ff @(posedge clk) begin
		if (!nrst) begin
			mem_addr  <= '0;
			mem_wdata <= '0;
		end else begin
			mem_addr  <= next_addr;
			mem_wdata <= next_wdata;
		end
	end

	// Popped word stands until the next pop
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pop_data <= '0;
		end else begin
			pop_data <= next_pop;
		end
	end

	// Completion pulse
	always_ff @(posedge clk) begin
		if (!nrst) begin
			op_done <= 1'b0;
		end else begin
			op_done <= next_done;
		end
	end

	// Trap pulse lines up with the offending access; the access itself is not withheld
	always_ff @(posedge clk) begin
		if (!nrst) begin
			stack_error <= 1'b0;
		end else begin
			stack_error <= hit_over || hit_under || hit_wrap;
		end
	end

	// Event causes, registered beside the pulse so status sets one cycle after it
	always_ff @(posedge clk) begin
		if (!nrst) begin
			events <= '0;
		end else begin
			events <= {hit_wrap, hit_under, hit_over};
		end
	end

	sspu_regs u_regs (
		.clk       (clk),
		.nrst      (nrst),
		.reg_addr  (reg_addr),
		.reg_wdata (reg_wdata),
		.reg_wr    (reg_wr),
		.reg_rd    (reg_rd),
		.reg_rdata (reg_rdata),
		.irq       (irq),
		.events    (events),
		.sp        (stack_pointer_reg),
		.fp        (frame_pointer_reg),
		.limit     (limit),
		.check_en  (check_en)
	);
endmodule // sspu_core
`default_nettype wire

/* File: tb/sspu_core_props.sv */
// Port checker of the stack pointer unit
`include "sspu_map.svh"
`default_nettype none
module sspu_core_props #(
	parameter bit ALT_VARIANT = 1'b0
) (
	input wire logic                        clk,
	input wire logic                        nrst,
	input wire logic                        op_valid,
	input wire sspu_pkg::sspu_op_type       op_code,
	input wire sspu_pkg::sspu_word_type     op_data,
	input wire logic [22:0]                 pc,
	input wire logic [7:0]                  status_low_byte,
	input wire logic                        cpu_priority_level,
	input wire logic [13:0]                 frame_lit,
	input wire logic                        op_busy,
	input wire logic                        op_done,
	input wire sspu_pkg::sspu_word_type     stack_pointer_reg,
	input wire sspu_pkg::sspu_word_type     frame_pointer_reg,
	input wire logic                        mem_wr,
	input wire logic                        mem_rd,
	input wire sspu_pkg::sspu_word_type     mem_addr,
	input wire sspu_pkg::sspu_word_type     mem_wdata,
	input wire sspu_pkg::sspu_word_type     mem_rdata,
	input wire logic                        stack_error,
	input wire logic [`SSPU_REG_ADDR_W-1:0] reg_addr,
	input wire sspu_pkg::sspu_word_type     reg_wdata,
	input wire logic                        reg_wr
);
	import sspu_pkg::*;
	logic          armed;
	sspu_word_type lim;
	sspu_word_type floor_a;
	logic          acc;
	logic          take;
	// Floor follows the variant; access and take are shorthands
	assign floor_a = ALT_VARIANT ? `SSPU_SP_RESET_ALT : `SSPU_SP_RESET;
	assign acc = mem_wr | mem_rd;
	assign take = op_valid & ~op_busy;
	// Own copy of arming, since the checking state is not on the ports
	always_ff @(posedge clk) begin
		if (!nrst) begin
			armed <= 1'b0;
			lim   <= `SSPU_LIMIT_RESET;
		end else if (reg_wr && reg_addr == `SSPU_REG_LIMIT) begin
			armed <= 1'b1;
			lim   <= reg_wdata & `SSPU_EVEN_MASK;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	chk_sp_even: assert property (stack_pointer_reg[0] == 1'b0)
		else $error("stack pointer odd");
	chk_push_post_inc: assert property (take && op_code == SSPU_OP_PUSH |=> mem_wr
		&& mem_addr == $past(stack_pointer_reg) && mem_wdata == $past(op_data)
		&& stack_pointer_reg == $past(stack_pointer_reg) + 16'h0002 && op_done)
		else $error("push address or step wrong");
	chk_pop_pre_dec: assert property (take && op_code == SSPU_OP_POP |=> mem_rd && op_busy
		&& mem_addr == $past(stack_pointer_reg) - 16'h0002
		&& stack_pointer_reg == mem_addr ##2 op_done)
		else $error("pop address or step wrong");
	chk_call_words: assert property (take && op_code == SSPU_OP_CALL |=> mem_wr
		&& mem_wdata == $past(pc[15:0]) ##1 mem_wr && mem_addr == $past(mem_addr) + 16'h0002
		&& mem_wdata == {9'h000, $past(pc[22:16], 2)})
		else $error("call words wrong");
	chk_exc_word: assert property (take && op_code == SSPU_OP_EXC |=> ##1 mem_wr
		&& mem_wdata == {$past(status_low_byte, 2), $past(cpu_priority_level, 2),
		$past(pc[22:16], 2)})
		else $error("exception word wrong");
	chk_link_frame: assert property (take && op_code == SSPU_OP_LINK |=> mem_wr
		&& mem_wdata == $past(frame_pointer_reg) ##1 op_done
		&& frame_pointer_reg == $past(stack_pointer_reg)
		&& stack_pointer_reg == frame_pointer_reg + {$past(frame_lit[13:1], 2), 1'b0})
		else $error("frame create wrong");
	chk_unlink_frame: assert property (take && op_code == SSPU_OP_UNLINK
		|=> stack_pointer_reg == $past(frame_pointer_reg) ##1 mem_rd
		&& mem_addr == $past(stack_pointer_reg) - 16'h0002
		##2 op_done && frame_pointer_reg == $past(mem_rdata))
		else $error("frame release wrong");
	chk_floor_trap: assert property (acc && mem_addr < floor_a |-> stack_error)
		else $error("no trap below floor");
	chk_limit_trap: assert property (acc && armed && mem_addr > lim |-> stack_error)
		else $error("no trap above limit");
	chk_trap_cause: assert property (stack_error |-> acc && (mem_addr < floor_a
		|| armed && (mem_addr > lim || mem_addr == 16'hFFFE)))
		else $error("trap without cause");
endmodule // sspu_core_props
bind sspu_core sspu_core_props #(.ALT_VARIANT(ALT_VARIANT)) sspu_core_props_i (
	.clk(clk), .nrst(nrst), .op_valid(op_valid), .op_code(op_code), .op_data(op_data),
	.pc(pc), .status_low_byte(status_low_byte), .cpu_priority_level(cpu_priority_level),
	.frame_lit(frame_lit), .op_busy(op_busy), .op_done(op_done),
	.stack_pointer_reg(stack_pointer_reg), .frame_pointer_reg(frame_pointer_reg),
	.mem_wr(mem_wr), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
	.mem_rdata(mem_rdata), .stack_error(stack_error), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr)
);
`default_nettype wire

/* File: tb/sspu_mem_model.sv */
// Data memory on the far side of the stack unit
`default_nettype none
module sspu_mem_model (
	input wire logic                    clk,
	input wire logic                    mem_wr,
	input wire logic                    mem_rd,
	input wire sspu_pkg::sspu_word_type mem_addr,
	input wire sspu_pkg::sspu_word_type mem_wdata,
	output sspu_pkg::sspu_word_type     mem_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	import sspu_pkg::*;
	sspu_word_type mem [0:32767];
	initial mem_rdata = 16'h0000;
	// Read data stands only in the cycle after the strobe; it toggles elsewhere so
	// a late capture cannot pass for a real one
	always @(posedge clk) begin
		if (mem_wr)
			mem[mem_addr[15:1]] <= mem_wdata;
		if (mem_rd)
			mem_rdata <= mem[mem_addr[15:1]];
		else
			mem_rdata <= ~mem_rdata;
	end
endmodule // sspu_mem_model
`default_nettype wire

/* File: tb/test_sspu_core.sv */
// Self-checking bench of the stack pointer unit
`include "sspu_map.svh"
`default_nettype none
module test_sspu_core;
	timeunit 1ns;
	timeprecision 1ps;
	import sspu_pkg::*;
	logic clk = 1'b0, nrst = 1'b0, op_valid = 1'b0, cpu_priority_level = 1'b0;
	logic op_busy, op_done, mem_wr, mem_rd, stack_error, irq;
	logic reg_wr = 1'b0, reg_rd = 1'b0;
	logic [`SSPU_REG_ADDR_W-1:0] reg_addr = 3'h0;
	sspu_op_type   op_code = SSPU_OP_PUSH;
	sspu_word_type op_data = 16'h0000, reg_wdata = 16'h0000;
	sspu_word_type pop_data, stack_pointer_reg, frame_pointer_reg;
	sspu_word_type mem_addr, mem_wdata, mem_rdata, reg_rdata, d, s, f;
	logic [22:0] pc = 23'h000000;
	logic [7:0]  status_low_byte = 8'h00;
	logic [13:0] frame_lit = 14'h0000;
	sspu_word_type q[$];
	int fail_count = 0, n_compared = 0, cyc = 0, seed = 6, i;
	sspu_core #(.ALT_VARIANT(1'b0)) sspu_core_i (.clk(clk), .nrst(nrst),
		.op_valid(op_valid), .op_code(op_code), .op_data(op_data), .pc(pc),
		.status_low_byte(status_low_byte), .cpu_priority_level(cpu_priority_level),
		.frame_lit(frame_lit), .op_busy(op_busy), .op_done(op_done), .pop_data(pop_data),
		.stack_pointer_reg(stack_pointer_reg), .frame_pointer_reg(frame_pointer_reg),
		.mem_wr(mem_wr), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .stack_error(stack_error), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.irq(irq));
	sspu_mem_model sspu_mem_model_i (.clk(clk), .mem_wr(mem_wr), .mem_rd(mem_rd),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
	// 20 MHz clock and a hang guard well above the expected run
	always #25 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc > 5000) begin
			fail_count++;
			complete_run;
		end
	end
	// Second stacked word: upper counter bits, with status and priority on exceptions
	function automatic sspu_word_type hi_word(input logic ex);
		return ex ? {status_low_byte, cpu_priority_level, pc[22:16]} : {9'h000, pc[22:16]};
	endfunction
	task automatic check(input string nm, input sspu_word_type e, input sspu_word_type g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One request; side inputs get fresh random values with it
	task automatic op(input sspu_op_type c, input sspu_word_type v);
		@(posedge clk);
		op_valid <= 1'b1;
		op_code <= c;
		op_data <= v;
		pc <= 23'($random(seed));
		status_low_byte <= 8'($random(seed));
		cpu_priority_level <= 1'($random(seed));
		frame_lit <= 14'($random(seed));
		@(posedge clk);
		op_valid <= 1'b0;
		#1;
		for (int k = 0; k < 8 && op_done !== 1'b1; k++) begin
			@(posedge clk);
			#1;
		end
		check("op_done", 16'h0001, op_done);
	endtask
	task automatic wr(input logic [2:0] a, input sspu_word_type v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input sspu_word_type e, input string nm);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check(nm, e, reg_rdata);
	endtask
	task automatic reset_and_check(input int n);
		@(posedge clk);
		nrst <= 1'b0;
		repeat (n) @(posedge clk);
		nrst <= 1'b1;
		#1;
		check("sp", `SSPU_SP_RESET, stack_pointer_reg);
		check("fp", 16'h0000, frame_pointer_reg);
		rd(`SSPU_REG_LIMIT, 16'h0000, "limit");
		rd(`SSPU_REG_STATUS, 16'h0000, "status");
		rd(`SSPU_REG_MASK, 16'h0000, "mask");
	endtask
	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		reset_and_check(12);
		op(SSPU_OP_PUSH, 16'h5A5A);
		op(SSPU_OP_PUSH, 16'h3636);
		check("sp", 16'h0804, stack_pointer_reg);
		op(SSPU_OP_POP, 16'h0000);
		check("pop", 16'h3636, pop_data);
		// Random words come back in reverse order
		for (i = 0; i < 8; i++) begin
			d = 16'($random(seed));
			q.push_back(d);
			op(SSPU_OP_PUSH, d);
		end
		for (i = 0; i < 8; i++) begin
			op(SSPU_OP_POP, 16'h0000);
			check("pop", q.pop_back(), pop_data);
		end
		check("sp", 16'h0802, stack_pointer_reg);
		// Call, then exception entry, read back by two pops each
		for (i = 0; i < 2; i++) begin
			op(i[0] ? SSPU_OP_EXC : SSPU_OP_CALL, 16'h0000);
			s = hi_word(i[0]);
			f = pc[15:0];
			op(SSPU_OP_POP, 16'h0000);
			check("hi", s, pop_data);
			op(SSPU_OP_POP, 16'h0000);
			check("lo", f, pop_data);
		end
		// Frame create and its paired release
		d = 16'($random(seed));
		op(SSPU_OP_LOAD_FP, d);
		check("fp", d, frame_pointer_reg);
		s = stack_pointer_reg;
		op(SSPU_OP_LINK, 16'h0000);
		check("fp", s + 16'h0002, frame_pointer_reg);
		check("sp", s + 16'h0002 + {frame_lit[13:1], 1'b0}, stack_pointer_reg);
		op(SSPU_OP_UNLINK, 16'h0000);
		check("fp", d, frame_pointer_reg);
		check("sp", s, stack_pointer_reg);
		op(SSPU_OP_LOAD_SP, 16'h0A03);
		check("sp", 16'h0A02, stack_pointer_reg);
		// Above a zero limit, but checking is not armed yet
		op(SSPU_OP_PUSH, 16'h0000);
		rd(`SSPU_REG_STATUS, 16'h0000, "status");
		wr(`SSPU_REG_MASK, 16'h0001);
		rd(`SSPU_REG_MASK, 16'h0001, "mask");
		// Floor trap, masked away from the interrupt
		op(SSPU_OP_LOAD_SP, 16'h0800);
		op(SSPU_OP_POP, 16'h0000);
		@(posedge clk);
		#1;
		check("irq", 16'h0000, irq);
		rd(`SSPU_REG_STATUS, 16'h0002, "status");
		wr(`SSPU_REG_LIMIT, 16'h0A05);
		rd(`SSPU_REG_LIMIT, 16'h0A04, "limit");
		// At the limit is fine, one word above traps
		op(SSPU_OP_LOAD_SP, 16'h0A04);
		op(SSPU_OP_PUSH, 16'h0000);
		rd(`SSPU_REG_STATUS, 16'h0000, "status");
		op(SSPU_OP_PUSH, 16'h0000);
		@(posedge clk);
		#1;
		check("irq", 16'h0001, irq);
		rd(`SSPU_REG_STATUS, 16'h0001, "status");
		check("irq", 16'h0000, irq);
		// Push at the top of data space wraps
		wr(`SSPU_REG_LIMIT, 16'hFFFE);
		op(SSPU_OP_LOAD_SP, 16'hFFFE);
		op(SSPU_OP_PUSH, 16'h0000);
		rd(`SSPU_REG_STATUS, 16'h0004, "status");
		rd(`SSPU_REG_SP, 16'h0000, "sp_reg");
		wr(3'h5, 16'hFFFF);
		rd(3'h5, 16'h0000, "unmapped");
		// A second reset disarms checking
		reset_and_check(2);
		op(SSPU_OP_LOAD_SP, 16'h0A00);
		op(SSPU_OP_PUSH, 16'h0000);
		rd(`SSPU_REG_STATUS, 16'h0000, "status");
		complete_run;
	end
endmodule // test_sspu_core
`default_nettype wire
